// ===== common/atadc_pkg.sv
// Package: register offsets, field positions and codes for the ATA command front end
package atadc_pkg;
  // APB byte offsets (one word each)
  localparam logic [7:0] OFS_CMDREG   = 8'h00;  // Host-side Command register (8-bit)
  localparam logic [7:0] OFS_DEVHEAD  = 8'h04;  // Device/Head register
  localparam logic [7:0] OFS_STATUS   = 8'h08;  // Status register (read)
  localparam logic [7:0] OFS_ERROR    = 8'h0c;  // Error register (read)
  localparam logic [7:0] OFS_DATA     = 8'h10;  // Data register, 16-bit PIO word
  localparam logic [7:0] OFS_CTRL     = 8'h14;  // Device control: nIEN
  localparam logic [7:0] OFS_SECCNT   = 8'h18;  // Sector count / signature
  localparam logic [7:0] OFS_LBALO    = 8'h1c;  // LBA low / signature
  localparam logic [7:0] OFS_LBAMID   = 8'h20;  // LBA mid / signature
  localparam logic [7:0] OFS_LBAHI    = 8'h24;  // LBA high / signature
  localparam logic [7:0] OFS_QDEPTH   = 8'h28;  // Queued command count (read)
  localparam logic [7:0] OFS_FINISH   = 8'h2c;  // Back-end completion / release strobe
  localparam logic [7:0] OFS_MULT     = 8'h30;  // Multiple block size (read)
  localparam logic [7:0] OFS_UDMA     = 8'h34;  // Ultra DMA enable / burst count
  // Field positions
  localparam int DEV_BIT   = 4;
  localparam int NIEN_BIT  = 1;
  localparam int ST_BSY    = 7;
  localparam int ST_DF     = 5;
  localparam int ST_DRQ    = 3;
  localparam int ST_ERR    = 0;
  localparam int ER_ABRT   = 2;
  localparam int FIN_DONE  = 0;
  localparam int FIN_ERR   = 1;
  localparam int FIN_DF    = 2;
  localparam int FIN_REL   = 3;
  // Sector geometry
  localparam int SECTOR_WORDS = 256;
  localparam int SECTOR_BYTES = 512;
  // Command codes
  localparam logic [7:0] CMD_READ_SEC   = 8'h20;
  localparam logic [7:0] CMD_WRITE_SEC  = 8'h30;
  localparam logic [7:0] CMD_READ_MULT  = 8'hc4;
  localparam logic [7:0] CMD_WRITE_MULT = 8'hc5;
  localparam logic [7:0] CMD_SET_MULT   = 8'hc6;
  localparam logic [7:0] CMD_READ_QUEUE = 8'hc7;
  localparam logic [7:0] CMD_WRITE_QUEUE= 8'hcc;
  localparam logic [7:0] CMD_NOP        = 8'h00;
  localparam logic [7:0] CMD_OBS_RECAL  = 8'h10;
  localparam logic [7:0] CMD_OBS_SEEK   = 8'h70;
  // Reset values
  localparam logic [7:0] STATUS_RST  = 8'h00;
  localparam logic [7:0] MULT_RST    = 8'h01;
  // Signature left in the command block at reset (values arbitrary)
  localparam logic [7:0] SIG_SECCNT  = 8'h01;
  localparam logic [7:0] SIG_LBALO   = 8'h01;
  localparam logic [7:0] SIG_REG_MID = 8'h00;
  localparam logic [7:0] SIG_REG_HI  = 8'h00;
  localparam logic [7:0] SIG_PKT_MID = 8'h3c;
  localparam logic [7:0] SIG_PKT_HI  = 8'hc3;
  // Accepted multiple sizes (power of two up to this)
  localparam logic [7:0] MULT_MAX    = 8'h80;
  typedef enum logic [3:0] {
    ATADC_IDLE = 4'b0001,
    ATADC_DRQ  = 4'b0010,
    ATADC_BUSY = 4'b0100,
    ATADC_REL  = 4'b1000
  } atadc_state_e;
endpackage : atadc_pkg

// ===== sim/atadc_chk.sv
// Checker: port-level properties of the command front end
`timescale 1ns/100ps
module atadc_chk (
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        rst,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  // Device side
  input wire logic        dmack_n,
  input wire logic        intrq,
  input wire logic        drq,
  input wire logic        busy,
  input wire logic        selected,
  input wire logic        dev_num,
  input wire logic        udma_burst
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic acc_wr;
  logic nien_reg;
  logic dev_reg;
  logic uen_reg;
  assign acc_wr = psel && penable && pwrite;
  // Shadow copies of the host-written control bits
  always_ff @(posedge ref_clk) begin
    nien_reg <= rst ? 1'b0 : (acc_wr && paddr == atadc_pkg::OFS_CTRL) ?
                pwdata[atadc_pkg::NIEN_BIT] : nien_reg;
    dev_reg  <= rst ? 1'b0 : (acc_wr && paddr == atadc_pkg::OFS_DEVHEAD) ?
                pwdata[atadc_pkg::DEV_BIT] : dev_reg;
    uen_reg  <= rst ? 1'b0 : (acc_wr && paddr == atadc_pkg::OFS_UDMA) ? pwdata[0] : uen_reg;
  end
  AST_SELECT_MATCH: assert property (!$past(rst) |-> selected == (dev_reg == dev_num))
    else $error("selected disagrees with device bit");
  AST_DEVNUM_HELD: assert property (!$past(rst) && !$past(rst, 2) |-> $stable(dev_num))
    else $error("device number moved");
  AST_REG_WIDTH: assert property (psel && penable && !pwrite |->
    ((paddr == atadc_pkg::OFS_DATA) ? prdata[31:16] == 16'h0 : prdata[31:8] == 24'h0))
    else $error("read data wider than register");
  AST_INTRQ_GATED: assert property (intrq |-> !nien_reg && selected)
    else $error("intrq while masked");
  AST_DRQ_BSY_EXCL: assert property (drq |-> !busy)
    else $error("drq with busy");
  AST_UNSEL_CMD: assert property (acc_wr && !selected && paddr == atadc_pkg::OFS_CMDREG
    |=> $stable(busy) && $stable(drq))
    else $error("unselected command changed state");
  AST_CMD_ACCEPT: assert property (acc_wr && selected && !busy && !drq &&
    paddr == atadc_pkg::OFS_CMDREG && pwdata[7:0] == atadc_pkg::CMD_WRITE_SEC |-> ##[1:4] drq)
    else $error("command not accepted");
  AST_FINISH_CLEARS: assert property (acc_wr && selected && paddr == atadc_pkg::OFS_FINISH &&
    (pwdata[atadc_pkg::FIN_DONE] || pwdata[atadc_pkg::FIN_REL]) |-> ##[1:2] (!busy && !drq))
    else $error("busy or drq left after finish");
  AST_BURST_END: assert property ($rose(dmack_n) |-> ##[0:2] !udma_burst)
    else $error("burst outlived acknowledge");
  AST_BURST_EN: assert property (udma_burst |-> uen_reg)
    else $error("burst while disabled");
endmodule : atadc_chk

// ===== sim/atadc_host_dma.sv
// Host-side model: device strap and Ultra DMA acknowledge
`timescale 1ns/100ps
module atadc_host_dma (
  // Clock
  input  wire logic       ref_clk,
  // Burst request from bench
  input  wire logic       go,
  input  wire logic [7:0] len,
  // Host pins
  output logic            dmack_n,
  output logic            dev_strap
);
  logic [7:0] cnt_reg = 8'h00;
  assign dev_strap = 1'b1;
  always @(posedge ref_clk) begin
    cnt_reg <= (cnt_reg != 8'h00) ? cnt_reg - 8'h01 : (go ? len : 8'h00);
  end
  // One burst: acknowledge held low for len cycles, then negated
  assign dmack_n = (cnt_reg == 8'h00);
endmodule : atadc_host_dma

// ===== sim/testbench.sv
// Testbench: APB-driven checks of the command front end
`timescale 1ns/100ps
module testbench;
  // Clock, reset and APB
  logic        ref_clk;
  logic        rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  // Host pins and burst request
  logic        dev_strap;
  logic        dmack_n;
  logic        go;
  logic [7:0]  len;
  // Device outputs
  logic        intrq;
  logic        drq;
  logic        busy;
  logic        selected;
  logic        dev_num;
  logic        udma_burst;
  int          fail_count = 0;
  int          n_compared = 0;
  int          cycles     = 0;
  atadc_core atadc_core_i (.ref_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb(4'hf), .prdata, .pready, .pslverr(), .dev_strap, .dmack_n, .intrq, .drq,
    .busy, .selected, .dev_num, .udma_burst);
  atadc_host_dma atadc_host_dma_i (.ref_clk, .go, .len, .dmack_n, .dev_strap);
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  task automatic conclude;
    $display("Compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : conclude
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      conclude;
    end
  end
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", nm, e, g);
      fail_count++;
    end
  endtask : cmp
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    r = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask : apb
  task automatic t_select;
    logic [31:0] r;
    apb(1'b0, atadc_pkg::OFS_SECCNT, 32'h0, r);
    cmp("sig_seccnt", {24'h0, atadc_pkg::SIG_SECCNT}, r);
    apb(1'b0, atadc_pkg::OFS_LBAMID, 32'h0, r);
    cmp("sig_lbamid", {24'h0, atadc_pkg::SIG_REG_MID}, r);
    apb(1'b1, atadc_pkg::OFS_DEVHEAD, 32'hef, r);
    cmp("sel_dev0", 32'h0, {31'h0, selected});
    apb(1'b1, atadc_pkg::OFS_DEVHEAD, 32'h10, r);
    cmp("sel_dev1", 32'h1, {31'h0, selected});
    cmp("dev_num", 32'h1, {31'h0, dev_num});
    $display("t_select done");
  endtask : t_select
  task automatic t_abort;
    logic [7:0]  c [3];
    logic [31:0] r;
    c = '{atadc_pkg::CMD_NOP, atadc_pkg::CMD_OBS_RECAL, atadc_pkg::CMD_OBS_SEEK};
    foreach (c[k]) begin
      apb(1'b1, atadc_pkg::OFS_CMDREG, {24'h0, c[k]}, r);
      repeat (2) @(posedge ref_clk);
      cmp("abort_intrq", 32'h1, {31'h0, intrq});
      apb(1'b0, atadc_pkg::OFS_STATUS, 32'h0, r);
      cmp("abort_status", 32'h01, r & 32'h89);
      apb(1'b0, atadc_pkg::OFS_ERROR, 32'h0, r);
      cmp("abort_error", 32'h04, r & 32'h04);
    end
    $display("t_abort done");
  endtask : t_abort
  task automatic t_pio;
    logic [31:0] r;
    int          n;
    apb(1'b1, atadc_pkg::OFS_CMDREG, {24'h0, atadc_pkg::CMD_WRITE_SEC}, r);
    for (n = 0; n < 100 && drq !== 1'b1; n++) @(posedge ref_clk);
    for (int i = 0; i < atadc_pkg::SECTOR_WORDS; i++) begin
      cmp("drq_in_block", 32'h1, {31'h0, drq});
      apb(1'b1, atadc_pkg::OFS_DATA, 32'(i), r);
    end
    repeat (2) @(posedge ref_clk);
    cmp("drq_after_block", 32'h0, {31'h0, drq});
    apb(1'b0, atadc_pkg::OFS_STATUS, 32'h0, r);
    cmp("pio_status", 32'h0, r & 32'h89);
    apb(1'b1, atadc_pkg::OFS_CMDREG, {24'h0, atadc_pkg::CMD_READ_QUEUE}, r);
    cmp("queued_busy_intrq", 32'h2, {30'h0, busy, intrq});
    apb(1'b0, atadc_pkg::OFS_QDEPTH, 32'h0, r);
    cmp("queue_count", 32'h1, r);
    apb(1'b1, atadc_pkg::OFS_CMDREG, {24'h0, atadc_pkg::CMD_NOP}, r);
    apb(1'b0, atadc_pkg::OFS_ERROR, 32'h0, r);
    cmp("busy_cmd_ignored", 32'h0, r & 32'h04);
    apb(1'b1, atadc_pkg::OFS_FINISH, 32'h3, r);
    repeat (2) @(posedge ref_clk);
    cmp("done_bsy_drq", 32'h0, {30'h0, busy, drq});
    cmp("done_intrq", 32'h1, {31'h0, intrq});
    apb(1'b1, atadc_pkg::OFS_CTRL, 32'h2, r);
    cmp("masked_intrq", 32'h0, {31'h0, intrq});
    apb(1'b1, atadc_pkg::OFS_CTRL, 32'h0, r);
    cmp("unmasked_intrq", 32'h1, {31'h0, intrq});
    apb(1'b0, atadc_pkg::OFS_STATUS, 32'h0, r);
    cmp("fault_status", 32'h01, r & 32'h89);
    apb(1'b0, atadc_pkg::OFS_QDEPTH, 32'h0, r);
    cmp("queue_empty", 32'h0, r);
    $display("t_pio done");
  endtask : t_pio
  task automatic t_unsel;
    logic [31:0] r;
    apb(1'b1, atadc_pkg::OFS_DEVHEAD, 32'h0, r);
    apb(1'b1, atadc_pkg::OFS_CMDREG, {24'h0, atadc_pkg::CMD_WRITE_SEC}, r);
    repeat (3) @(posedge ref_clk);
    cmp("unsel_state", 32'h0, {30'h0, busy, drq});
    apb(1'b1, atadc_pkg::OFS_DEVHEAD, 32'h10, r);
    $display("t_unsel done");
  endtask : t_unsel
  task automatic t_mult;
    logic [31:0] r;
    logic [7:0]  cnt [2];
    cnt = '{8'h02, 8'h03};
    foreach (cnt[k]) begin
      apb(1'b1, atadc_pkg::OFS_SECCNT, {24'h0, cnt[k]}, r);
      apb(1'b1, atadc_pkg::OFS_CMDREG, {24'h0, atadc_pkg::CMD_SET_MULT}, r);
      repeat (3) @(posedge ref_clk);
      apb(1'b0, atadc_pkg::OFS_MULT, 32'h0, r);
      cmp("mult_size", 32'h2, r);
      apb(1'b0, atadc_pkg::OFS_ERROR, 32'h0, r);
      cmp("mult_abort", {29'h0, k[0], 2'h0}, r & 32'h04);
    end
    apb(1'b1, atadc_pkg::OFS_CMDREG, {24'h0, atadc_pkg::CMD_WRITE_MULT}, r);
    for (int i = 0; i < 2 * atadc_pkg::SECTOR_WORDS; i++) begin
      if (i == atadc_pkg::SECTOR_WORDS)
        cmp("mult_mid_drq", 32'h1, {31'h0, drq});
      apb(1'b1, atadc_pkg::OFS_DATA, 32'(i), r);
    end
    repeat (2) @(posedge ref_clk);
    cmp("mult_end_drq", 32'h0, {31'h0, drq});
    $display("t_mult done");
  endtask : t_mult
  task automatic t_udma;
    logic [31:0] r;
    for (int en = 1; en >= 0; en--) begin
      apb(1'b1, atadc_pkg::OFS_UDMA, 32'(en), r);
      go  <= 1'b1;
      len <= 8'h08;
      @(posedge ref_clk);
      go  <= 1'b0;
      repeat (5) @(posedge ref_clk);
      cmp("burst_mid", 32'(en), {31'h0, udma_burst});
      repeat (8) @(posedge ref_clk);
      cmp("burst_end", 32'h0, {31'h0, udma_burst});
      apb(1'b0, atadc_pkg::OFS_UDMA, 32'h0, r);
      cmp("burst_count", 32'h2 | 32'(en), r);
    end
    $display("t_udma done");
  endtask : t_udma
  initial begin
    rst     = 1'b1;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    go      = 1'b0;
    len     = 8'h00;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    t_select;
    t_abort;
    t_pio;
    t_unsel;
    t_mult;
    t_udma;
    conclude;
  end
endmodule : testbench
bind atadc_core atadc_chk atadc_chk_i (.ref_clk, .rst, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .dmack_n, .intrq, .drq, .busy, .selected, .dev_num, .udma_burst);

// ===== verilog/atadc_core.sv
// ATA device command front end with APB register access
// Operation
// - Selected only when DEV equals device number
// - Non-data register transfers are 8 bits
// - One DRQ assertion moves complete block
// - Multiple block size whole sectors, SET MULTIPLE
// - Sector is 256 words, 512 bytes
// - Reserved bits sent as zero
// - Reserved bits ignored on receipt; SET MULTIPLE takes its size from pwdata[15:8] when that byte is valid
// - Reserved code value aborts command
// - Abort sets ABRT and ERR
// - Obsolete command aborted or completed
// - INTRQ asserted from pending only while nIEN clear
// - Unrecoverable error sets ERR or DF
// - Signature loaded into command block registers
// - Only overlapped commands queued; queue holds accepted
// - Ultra DMA burst spans DMACK assertion to negation
// - Bus release clears DRQ and BSY early
// - Accept command when BSY clear at write; a full queue (QUEUE_DEPTH) refuses queued codes even with BSY clear
// - Completion posts status, clears BSY/DRQ, interrupts
//
// The implementer's own choices: the register offsets and the APB register port.
`timescale 1ns/100ps
module atadc_core #(
  parameter int QUEUE_DEPTH  = 4,
  parameter int PACKET_DEV   = 0,
  parameter int ABORT_OBSOLETE = 1
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Straps
  input  wire logic        dev_strap,
  // Ultra DMA acknowledge, active low
  input  wire logic        dmack_n,
  // Device outputs
  output logic             intrq,
  output logic             drq,
  output logic             busy,
  output logic             selected,
  output logic             dev_num,
  output logic             udma_burst
);
  // Whole device state, registered once per clock
  typedef struct packed {
    atadc_pkg::atadc_state_e st;
    logic        devnum;
    logic        strap_taken;
    logic        dev_sel;
    logic        nien;
    logic        pend;
    logic [7:0]  status;
    logic [7:0]  error;
    logic [7:0]  cmd;
    logic [7:0]  mult;
    logic [8:0]  words;
    logic [7:0]  secs;
    // Command block registers and queued command count
    logic [7:0]  seccnt;
    logic [7:0]  lbalo;
    logic [7:0]  lbamid;
    logic [7:0]  lbahi;
    logic [7:0]  qcnt;
    // Ultra DMA tracking, then PIO data word and read data capture
    logic        udma_en;
    logic        dmack_d;
    logic        burst;
    logic [15:0] bursts;
    logic [15:0] data;
    logic [31:0] rd;
  } atadc_state_s;

  atadc_state_s s_reg;
  atadc_state_s s_next;

  // Command decoders
  function automatic logic is_obsolete(input logic [7:0] c);
    is_obsolete = (c == atadc_pkg::CMD_OBS_RECAL) || (c == atadc_pkg::CMD_OBS_SEEK);
  endfunction : is_obsolete

  function automatic logic is_queued(input logic [7:0] c);
    is_queued = (c == atadc_pkg::CMD_READ_QUEUE) || (c == atadc_pkg::CMD_WRITE_QUEUE);
  endfunction : is_queued

  function automatic logic is_mult(input logic [7:0] c);
    is_mult = (c == atadc_pkg::CMD_READ_MULT) || (c == atadc_pkg::CMD_WRITE_MULT);
  endfunction : is_mult

  function automatic logic is_pio(input logic [7:0] c);
    is_pio = (c == atadc_pkg::CMD_READ_SEC) || (c == atadc_pkg::CMD_WRITE_SEC) ||
             is_mult(c);
  endfunction : is_pio

  function automatic logic valid_mult(input logic [7:0] m);
    valid_mult = (m != 8'h00) && ((m & (m - 8'h01)) == 8'h00) && (m <= atadc_pkg::MULT_MAX);
  endfunction : valid_mult

  // APB access qualifiers; zero wait states
  logic        wr_acc;
  logic        rd_acc;
  logic        rd_setup;
  logic        byte0;
  logic        dev_match;
  logic [31:0] rdata;

  assign wr_acc  = psel && penable && pwrite;
  assign rd_acc  = psel && penable && !pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign dev_match = s_reg.dev_sel == s_reg.devnum;
  assign byte0   = pstrb[0];
  assign pready  = 1'b1;
  assign pslverr = 1'b0;

  // Register read mux; reserved and unused bits read as zero
  always_comb begin
    rdata = 32'h0;
    case (paddr)
      atadc_pkg::OFS_DEVHEAD: rdata[atadc_pkg::DEV_BIT] = s_reg.dev_sel;
      atadc_pkg::OFS_STATUS:  rdata[7:0] = s_reg.status;
      atadc_pkg::OFS_ERROR:   rdata[7:0] = s_reg.error;
      atadc_pkg::OFS_DATA:    rdata[15:0] = s_reg.data;
      atadc_pkg::OFS_CTRL:    rdata[atadc_pkg::NIEN_BIT] = s_reg.nien;
      atadc_pkg::OFS_SECCNT:  rdata[7:0] = s_reg.seccnt;
      atadc_pkg::OFS_LBALO:   rdata[7:0] = s_reg.lbalo;
      atadc_pkg::OFS_LBAMID:  rdata[7:0] = s_reg.lbamid;
      atadc_pkg::OFS_LBAHI:   rdata[7:0] = s_reg.lbahi;
      atadc_pkg::OFS_QDEPTH:  rdata[7:0] = s_reg.qcnt;
      atadc_pkg::OFS_MULT:    rdata[7:0] = s_reg.mult;
      atadc_pkg::OFS_UDMA:    rdata[7:0] = {s_reg.bursts[6:0], s_reg.udma_en};
      default:                rdata = 32'h0;
    endcase
  end

  always_comb begin
    logic       sel;
    logic       end_ok;
    logic       end_abort;
    logic       end_err;
    logic       end_df;
    logic [7:0] c;
    s_next    = s_reg;
    sel       = dev_match;
    end_ok    = 1'b0;
    end_abort = 1'b0;
    end_err   = 1'b0;
    end_df    = 1'b0;
    c         = pwdata[7:0];
    // Read data captured in the setup phase, stands through the access phase
    if (rd_setup)
      s_next.rd = rdata;
    if (!s_reg.strap_taken) begin
      s_next.devnum      = dev_strap;
      s_next.strap_taken = 1'b1;
    end
    // Ultra DMA burst tracking
    s_next.dmack_d = dmack_n;
    if (s_reg.udma_en && !dmack_n && s_reg.dmack_d) begin
      s_next.burst  = 1'b1;
      s_next.bursts = s_reg.bursts + 16'h0001;
    end
    if (dmack_n)
      s_next.burst = 1'b0;
    if (rd_acc && sel && paddr == atadc_pkg::OFS_STATUS)
      s_next.pend = 1'b0;
    if (rd_acc && sel && paddr == atadc_pkg::OFS_DATA && s_reg.st == atadc_pkg::ATADC_DRQ) begin
      s_next.words = s_reg.words + 9'h001;
    end
    if (wr_acc && byte0) begin
      // Device/Head and control reach both devices; the rest only the selected one
      if (paddr == atadc_pkg::OFS_DEVHEAD)
        s_next.dev_sel = pwdata[atadc_pkg::DEV_BIT];
      else if (paddr == atadc_pkg::OFS_CTRL)
        s_next.nien = pwdata[atadc_pkg::NIEN_BIT];
      else if (sel) begin
        case (paddr)
          atadc_pkg::OFS_SECCNT: s_next.seccnt = pwdata[7:0];
          atadc_pkg::OFS_LBALO:  s_next.lbalo  = pwdata[7:0];
          atadc_pkg::OFS_LBAMID: s_next.lbamid = pwdata[7:0];
          atadc_pkg::OFS_LBAHI:  s_next.lbahi  = pwdata[7:0];
          atadc_pkg::OFS_UDMA:   s_next.udma_en = pwdata[0];
          atadc_pkg::OFS_DATA: begin
            if (s_reg.st == atadc_pkg::ATADC_DRQ) begin
              s_next.data  = pwdata[15:0];
              s_next.words = s_reg.words + 9'h001;
            end
          end
          atadc_pkg::OFS_FINISH: begin
            if (s_reg.st == atadc_pkg::ATADC_BUSY || s_reg.st == atadc_pkg::ATADC_REL) begin
              end_ok = pwdata[atadc_pkg::FIN_DONE];
              end_err = pwdata[atadc_pkg::FIN_ERR];
              end_df  = pwdata[atadc_pkg::FIN_DF];
              if (pwdata[atadc_pkg::FIN_REL] && s_reg.st == atadc_pkg::ATADC_BUSY &&
                  is_queued(s_reg.cmd) && !end_ok) begin
                s_next.st = atadc_pkg::ATADC_REL;
                s_next.status[atadc_pkg::ST_BSY] = 1'b0;
                s_next.status[atadc_pkg::ST_DRQ] = 1'b0;
              end
            end
          end
          atadc_pkg::OFS_CMDREG: begin
            // Taken only while BSY is clear; a full queue refuses queued codes
            if (!s_reg.status[atadc_pkg::ST_BSY] &&
                (!is_queued(c) || s_reg.qcnt < 8'(QUEUE_DEPTH))) begin
              s_next.cmd    = c;
              s_next.error  = 8'h00;
              s_next.status = 8'h00;
              s_next.status[atadc_pkg::ST_BSY] = 1'b1;
              s_next.st     = atadc_pkg::ATADC_BUSY;
              if (is_queued(c))
                s_next.qcnt = s_reg.qcnt + 8'h01;
              if (c == atadc_pkg::CMD_SET_MULT) begin
                if (valid_mult(pwdata[15:8]) || valid_mult(s_reg.seccnt)) begin
                  s_next.mult = valid_mult(pwdata[15:8]) ? pwdata[15:8] : s_reg.seccnt;
                  end_ok = 1'b1;
                end else
                  end_abort = 1'b1;
              end else if (is_obsolete(c)) begin
                if (ABORT_OBSOLETE != 0)
                  end_abort = 1'b1;
                else
                  end_ok = 1'b1;
              end else if (is_pio(c)) begin
                s_next.st    = atadc_pkg::ATADC_DRQ;
                s_next.words = 9'h000;
                s_next.secs  = 8'h00;
                s_next.status[atadc_pkg::ST_BSY] = 1'b0;
                s_next.status[atadc_pkg::ST_DRQ] = 1'b1;
              end else if (!is_queued(c) && c != atadc_pkg::CMD_NOP)
                end_abort = 1'b1;
              else if (c == atadc_pkg::CMD_NOP)
                end_abort = 1'b1;
            end
          end
          default: ;
        endcase
      end
    end
    // Block accounting: one sector is 256 words
    if (s_reg.st == atadc_pkg::ATADC_DRQ && s_next.words == 9'(atadc_pkg::SECTOR_WORDS)) begin
      s_next.words = 9'h000;
      s_next.secs  = s_reg.secs + 8'h01;
      if (is_mult(s_reg.cmd) &&
          (s_reg.secs + 8'h01) < s_reg.mult)
        s_next.st = atadc_pkg::ATADC_DRQ;
      else
        end_ok = 1'b1;
    end
    if (end_abort) begin
      s_next.error[atadc_pkg::ER_ABRT] = 1'b1;
      end_err = 1'b1;
    end
    // Completion: post status, drop BSY and DRQ, raise pending
    if (end_ok || end_abort || end_err || end_df) begin
      s_next.st = atadc_pkg::ATADC_IDLE;
      s_next.status[atadc_pkg::ST_BSY] = 1'b0;
      s_next.status[atadc_pkg::ST_DRQ] = 1'b0;
      s_next.status[atadc_pkg::ST_ERR] = end_err;
      s_next.status[atadc_pkg::ST_DF]  = end_df;
      s_next.pend = 1'b1;
      if (is_queued(s_reg.cmd) && s_reg.qcnt != 8'h00 && !is_queued(s_next.cmd))
        s_next.qcnt = s_reg.qcnt - 8'h01;
      else if (is_queued(s_reg.cmd) && s_reg.qcnt != 8'h00 && s_next.cmd == s_reg.cmd)
        s_next.qcnt = s_reg.qcnt - 8'h01;
    end
  end

  // Reset loads the signature into the command block
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_reg         <= '0;
      s_reg.st      <= atadc_pkg::ATADC_IDLE;
      s_reg.status  <= atadc_pkg::STATUS_RST;
      s_reg.mult    <= atadc_pkg::MULT_RST;
      s_reg.dmack_d <= 1'b1;
      s_reg.seccnt  <= atadc_pkg::SIG_SECCNT;
      s_reg.lbalo   <= atadc_pkg::SIG_LBALO;
      s_reg.lbamid  <= (PACKET_DEV != 0) ? atadc_pkg::SIG_PKT_MID : atadc_pkg::SIG_REG_MID;
      s_reg.lbahi   <= (PACKET_DEV != 0) ? atadc_pkg::SIG_PKT_HI : atadc_pkg::SIG_REG_HI;
    end else begin
      s_reg <= s_next;
    end
  end

  // Pin and bus outputs
  assign prdata     = s_reg.rd;
  assign intrq      = s_reg.pend && !s_reg.nien && dev_match;
  assign drq        = s_reg.status[atadc_pkg::ST_DRQ];
  assign busy       = s_reg.status[atadc_pkg::ST_BSY];
  assign selected   = dev_match;
  assign dev_num    = s_reg.devnum;
  assign udma_burst = s_reg.burst;
endmodule : atadc_core
